// ==== rtl/asrx_defs.vh ====
// Constants of the asynchronous serial receiver
// How it works
// - Receive-complete flag is high whenever the buffer holds an unread frame.
// - Clearing receiver enable flushes the buffer and drops receive-complete.
// - Interrupt request follows receive-complete while enabled; reading the last buffered frame clears it.
// - Error flags live in the FIFO with their frame, shown at read slot.
// - Error flags cannot be written and raise no interrupt.
// - Frame error shows the first stop bit of the next readable frame.
// - Only the first stop bit is checked; further stop bits are ignored.
// - Overrun when buffer full, shifter waiting and a new start bit arrives.
// - Overrun clears when a frame moves from shifter into buffer.
// - Parity error is zero for frames received while parity checking is disabled.
// - Checker runs when parity enable set; odd select picks parity sense.
// - Parity result stored with frame; kept until its data are read.
// - Disable is immediate, abandons frame, releases receive pin.
// - Sample at 16x baud normally, 8x in double speed.
// - Falling edge starts detection; samples 8-10 or 4-6 voted, high rejects.
// - Bit timing resynchronises on every accepted start bit.
// - Per-bit state machine of 16 or 8 states, state equals sample index.
// - Each bit decided by majority of its three centre samples.
// - A low voted first stop bit sets frame error for that frame.
// - Next start accepted right after stop voting; later in double speed.
// - Setting receiver enable starts reception and takes the receive pin.
// - Unused upper data bits read as zero for short characters.
`ifndef ASRX_DEFS_VH
`define ASRX_DEFS_VH
`define ASRX_SPB_NORM   5'h10
`define ASRX_SPB_DBL    5'h08
`define ASRX_V1_NORM    5'h08
`define ASRX_V3_NORM    5'h0A
`define ASRX_V1_DBL     5'h04
`define ASRX_V3_DBL     5'h06
`define ASRX_DBL_RESTART 5'h07
`define ASRX_FIFO_DEPTH 2
`define ASRX_ENT_W      12
`endif

// ==== rtl/asrx_fifo.v ====
// Two-entry receive buffer with registered read data
`timescale 1ns/100ps
module asrx_fifo #(
   parameter W = 12
) (
   input  wire         sys_clk_i,
   input  wire         reset_i,
   input  wire         flush_i,
   input  wire         push_i,
   input  wire [W-1:0] wdata_i,
   input  wire         pop_i,
   output reg  [W-1:0] rdata_o,
   output reg          empty_o,
   output reg          full_o
);
   reg [W-1:0] mem_q [0:1];
   reg         wp_q;
   reg         rp_q;
   reg [1:0]   cnt_q;
   wire        do_pop  = pop_i && (cnt_q != 2'h0);
   wire        do_push = push_i && (cnt_q != 2'h2);
   reg [1:0]   cnt_d;
   reg         rp_d;

   always @* begin
      cnt_d = cnt_q;
      rp_d  = rp_q;
      if (do_pop) begin
         rp_d = ~rp_q;
      end
      if (do_push && !do_pop) begin
         cnt_d = cnt_q + 2'h1;
      end else if (do_pop && !do_push) begin
         cnt_d = cnt_q - 2'h1;
      end
   end

   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         wp_q    <= 1'b0;
         rp_q    <= 1'b0;
         cnt_q   <= 2'h0;
         empty_o <= 1'b1;
         full_o  <= 1'b0;
         rdata_o <= {W{1'b0}};
         mem_q[0] <= {W{1'b0}};
         mem_q[1] <= {W{1'b0}};
      end else if (flush_i) begin
         wp_q    <= 1'b0;
         rp_q    <= 1'b0;
         cnt_q   <= 2'h0;
         empty_o <= 1'b1;
         full_o  <= 1'b0;
         rdata_o <= {W{1'b0}};
      end else begin
         if (do_push) begin
            mem_q[wp_q] <= wdata_i;
            wp_q        <= ~wp_q;
         end
         cnt_q   <= cnt_d;
         rp_q    <= rp_d;
         empty_o <= (cnt_d == 2'h0);
         full_o  <= (cnt_d == 2'h2);
         // Head entry: bypass a push into an empty slot
         if (do_push && (cnt_d == 2'h1) && (cnt_q == 2'h0 || do_pop)) begin
            rdata_o <= wdata_i;
         end else begin
            rdata_o <= mem_q[rp_d];
         end
      end
   end
endmodule // asrx_fifo

// ==== rtl/asrx_receiver.v ====
// Receive path of an asynchronous serial port
`timescale 1ns/100ps
`include "asrx_defs.vh"
module asrx_receiver #(
   parameter DATA_W = 9
) (
   input  wire              sys_clk_i,
   input  wire              reset_i,
   input  wire              os_tick_i,
   input  wire              rxd_i,
   input  wire              receiver_enable_bit_i,
   input  wire              rx_done_irq_enable_i,
   input  wire              double_speed_bit_i,
   input  wire              parity_check_enable_i,
   input  wire              parity_odd_select_i,
   input  wire [3:0]        char_bits_i,
   input  wire              stop_bits_select_i,
   input  wire              data_read_i,
   input  wire              status_write_i,
   input  wire [2:0]        status_wdata_i,
   output reg  [DATA_W-1:0] rx_data_register_o,
   output reg               rx_complete_flag_o,
   output reg               frame_err_flag_o,
   output reg               overrun_flag_o,
   output reg               parity_err_flag_o,
   output reg               rx_irq_o,
   output reg               pin_override_o
);
   localparam [4:0] ST_IDLE  = 5'b00001;
   localparam [4:0] ST_START = 5'b00010;
   localparam [4:0] ST_DATA  = 5'b00100;
   localparam [4:0] ST_PAR   = 5'b01000;
   localparam [4:0] ST_STOP  = 5'b10000;

   // Status writes and stop count are ignored on purpose
   localparam [3:0] DW4 = DATA_W;

   reg              sync1_q;
   reg              sync2_q;
   reg              prev_q;
   reg [4:0]        st_q;
   reg [4:0]        smp_q;
   reg [1:0]        ones_q;
   reg [3:0]        bit_q;
   reg [DATA_W-1:0] shf_q;
   reg              par_q;
   reg              pend_q;
   reg [DATA_W-1:0] pend_data_q;
   reg              pend_fe_q;
   reg              pend_pe_q;
   reg              ovr_q;
   reg              gap_q;

   wire [`ASRX_ENT_W-1:0] head;
   wire                   fifo_empty;
   wire                   fifo_full;

   wire [4:0] spb = double_speed_bit_i ? `ASRX_SPB_DBL : `ASRX_SPB_NORM;
   wire [4:0] v1  = double_speed_bit_i ? `ASRX_V1_DBL : `ASRX_V1_NORM;
   wire [4:0] v3  = double_speed_bit_i ? `ASRX_V3_DBL : `ASRX_V3_NORM;
   wire       in_vote = (smp_q >= v1) && (smp_q <= v3);
   wire [1:0] ones_n  = ones_q + {1'b0, sync2_q};
   wire       voted   = ones_n[1];
   wire       last_v  = os_tick_i && (smp_q == v3);
   wire       bit_end = os_tick_i && (smp_q == spb);
   wire       fall    = os_tick_i && prev_q && !sync2_q;

   // Mask of bits used by the configured character size
   wire [DATA_W-1:0] cmask = ~({DATA_W{1'b1}} << char_bits_i);

   // Pending frame moves to the buffer when a slot is free
   wire push = pend_q && !fifo_full;
   wire pop  = data_read_i && !fifo_empty;
   wire frame_done = (st_q == ST_STOP) && last_v;
   // Bits enter at the top, so the frame sits right-aligned after a shift
   wire [DATA_W-1:0] dbits = (shf_q >> (DW4 - char_bits_i)) & cmask;
   wire par_calc = ^dbits ^ parity_odd_select_i;
   wire pe_now = parity_check_enable_i && (par_calc != par_q);
   wire start_ok = (st_q == ST_START) && last_v && !voted;

   asrx_fifo #(
      .W(`ASRX_ENT_W)
   ) u_fifo (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .flush_i   (!receiver_enable_bit_i),
      .push_i    (push),
      .wdata_i   ({pend_fe_q, ovr_q, pend_pe_q, pend_data_q}),
      .pop_i     (pop),
      .rdata_o   (head),
      .empty_o   (fifo_empty),
      .full_o    (fifo_full)
   );

   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
      end else begin
         sync1_q <= rxd_i;
         sync2_q <= sync1_q;
      end
   end

   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         prev_q      <= 1'b1;
         st_q        <= ST_IDLE;
         smp_q       <= 5'h00;
         ones_q      <= 2'h0;
         bit_q       <= 4'h0;
         shf_q       <= {DATA_W{1'b0}};
         par_q       <= 1'b0;
         pend_q      <= 1'b0;
         pend_data_q <= {DATA_W{1'b0}};
         pend_fe_q   <= 1'b0;
         pend_pe_q   <= 1'b0;
         ovr_q       <= 1'b0;
         gap_q       <= 1'b0;
      end else if (!receiver_enable_bit_i) begin
         prev_q <= 1'b1;
         st_q   <= ST_IDLE;
         smp_q  <= 5'h00;
         ones_q <= 2'h0;
         pend_q <= 1'b0;
         ovr_q  <= 1'b0;
         gap_q  <= 1'b0;
      end else begin
         if (os_tick_i) begin
            prev_q <= sync2_q;
         end
         if (push) begin
            pend_q <= 1'b0;
            ovr_q  <= 1'b0;
         end
         case (st_q)
            ST_IDLE: begin
               if (gap_q) begin
                  // Double speed waits a little past the stop vote
                  if (os_tick_i) begin
                     smp_q <= smp_q + 5'h01;
                     if (smp_q == `ASRX_DBL_RESTART) begin
                        gap_q <= 1'b0;
                        smp_q <= 5'h00;
                     end
                  end
               end else if (fall) begin
                  st_q   <= ST_START;
                  smp_q  <= 5'h02;
                  ones_q <= 2'h0;
                  if (pend_q && fifo_full) begin
                     ovr_q <= 1'b1;
                  end
               end
            end
            ST_START, ST_DATA, ST_PAR, ST_STOP: begin
               if (os_tick_i) begin
                  smp_q <= bit_end ? 5'h01 : smp_q + 5'h01;
                  if (in_vote) begin
                     ones_q <= ones_n;
                  end
                  if (bit_end) begin
                     ones_q <= 2'h0;
                  end
               end
               if (st_q == ST_START && last_v && voted) begin
                  st_q  <= ST_IDLE;
                  smp_q <= 5'h00;
               end
               if (start_ok) begin
                  bit_q <= 4'h0;
               end
               if (bit_end && st_q == ST_START) begin
                  st_q <= ST_DATA;
               end
               if (last_v && st_q == ST_DATA) begin
                  shf_q <= {voted, shf_q[DATA_W-1:1]};
               end
               if (bit_end && st_q == ST_DATA) begin
                  bit_q <= bit_q + 4'h1;
                  if (bit_q == char_bits_i - 4'h1) begin
                     st_q <= parity_check_enable_i ? ST_PAR : ST_STOP;
                  end
               end
               if (last_v && st_q == ST_PAR) begin
                  par_q <= voted;
               end
               if (bit_end && st_q == ST_PAR) begin
                  st_q <= ST_STOP;
               end
               if (frame_done) begin
                  st_q        <= ST_IDLE;
                  smp_q       <= 5'h00;
                  gap_q       <= double_speed_bit_i;
                  pend_q      <= 1'b1;
                  pend_data_q <= dbits;
                  pend_fe_q   <= !voted;
                  pend_pe_q   <= pe_now;
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         rx_data_register_o <= {DATA_W{1'b0}};
         rx_complete_flag_o <= 1'b0;
         frame_err_flag_o   <= 1'b0;
         overrun_flag_o     <= 1'b0;
         parity_err_flag_o  <= 1'b0;
         rx_irq_o           <= 1'b0;
         pin_override_o     <= 1'b0;
      end else begin
         rx_data_register_o <= head[DATA_W-1:0];
         rx_complete_flag_o <= !fifo_empty && receiver_enable_bit_i;
         frame_err_flag_o   <= head[11] & !fifo_empty;
         overrun_flag_o     <= head[10] & !fifo_empty;
         parity_err_flag_o  <= head[9] & !fifo_empty;
         rx_irq_o           <= rx_done_irq_enable_i && !fifo_empty
                               && receiver_enable_bit_i;
         pin_override_o     <= receiver_enable_bit_i;
      end
   end
endmodule // asrx_receiver

// ==== test/asrx_monitor.sv ====
// Port-level checks on the serial receiver
`timescale 1ns/100ps
module asrx_monitor #(
   parameter DATA_W = 9
) (
   input wire              sys_clk_i,
   input wire              reset_i,
   input wire              receiver_enable_bit_i,
   input wire              rx_done_irq_enable_i,
   input wire [3:0]        char_bits_i,
   input wire              data_read_i,
   input wire [DATA_W-1:0] rx_data_register_o,
   input wire              rx_complete_flag_o,
   input wire              frame_err_flag_o,
   input wire              overrun_flag_o,
   input wire              parity_err_flag_o,
   input wire              rx_irq_o,
   input wire              pin_override_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   a_irq_follow: assert property (
      (rx_complete_flag_o && rx_done_irq_enable_i)[*2] |-> rx_irq_o)
      else $error("irq missing for pending frame");
   a_irq_quiet: assert property (
      (!rx_complete_flag_o || !rx_done_irq_enable_i)[*3] |-> $past(!rx_irq_o))
      else $error("irq without pending enabled frame");
   a_flush_empty: assert property (
      (!receiver_enable_bit_i)[*3] |-> !rx_complete_flag_o && !rx_irq_o)
      else $error("buffer not flushed while disabled");
   a_pin_release: assert property (
      $fell(receiver_enable_bit_i) |-> ##[0:2] !pin_override_o)
      else $error("pin not released");
   a_pin_take: assert property (
      $rose(receiver_enable_bit_i) |-> ##[0:2] pin_override_o)
      else $error("pin not taken");
   a_head_stable: assert property (
      (rx_complete_flag_o && !data_read_i && receiver_enable_bit_i)[*4] |->
      $stable({rx_data_register_o, frame_err_flag_o, overrun_flag_o,
      parity_err_flag_o})) else $error("head entry changed without read");
   a_upper_zero: assert property (
      (rx_complete_flag_o)[*3] |-> (rx_data_register_o >> char_bits_i) == 0)
      else $error("unused data bits not zero");
   a_flag_enabled: assert property (
      $rose(rx_complete_flag_o) |-> $past(receiver_enable_bit_i))
      else $error("frame stored while disabled");
endmodule // asrx_monitor
bind asrx_receiver asrx_monitor #(.DATA_W(DATA_W)) i_asrx_monitor (.*);

// ==== test/asrx_line_model.sv ====
// Remote transmitter driving the receive line
`timescale 1ns/100ps
module asrx_line_model (
   input  wire sys_clk_i,
   input  wire os_tick_i,
   output reg  rxd_o
);
   initial rxd_o = 1'b1;
   task automatic ticks(input [4:0] n);
      integer k;
      for (k = 0; k < n; k = k + 1) begin
         @(posedge sys_clk_i);
         while (os_tick_i !== 1'b1) @(posedge sys_clk_i);
      end
      @(negedge sys_clk_i);
   endtask
   // Low pulse too short to pass the start vote
   task automatic glitch(input [4:0] spb);
      rxd_o = 1'b0;
      ticks(5'h03);
      rxd_o = 1'b1;
      ticks(spb);
      ticks(spb);
   endtask
   task automatic send(input [8:0] d, input [3:0] n, input pen,
      input pbit, input stop, input [4:0] spb);
      integer i;
      rxd_o = 1'b0;
      ticks(spb);
      for (i = 0; i < n; i = i + 1) begin
         rxd_o = d[i];
         ticks(spb);
      end
      if (pen) begin
         rxd_o = pbit;
         ticks(spb);
      end
      rxd_o = stop;
      ticks(spb);
      rxd_o = 1'b1;
      ticks(spb);
   endtask
endmodule // asrx_line_model

// ==== test/testbench.sv ====
// Self-checking bench for the serial receiver
`timescale 1ns/100ps
module testbench;
   reg         sys_clk_i = 1'b0;
   reg         reset_i = 1'b1;
   reg         os_tick_i = 1'b0;
   reg         receiver_enable_bit_i = 1'b0;
   reg         rx_done_irq_enable_i = 1'b0;
   reg         double_speed_bit_i = 1'b0;
   reg         parity_check_enable_i = 1'b0;
   reg         parity_odd_select_i = 1'b0;
   reg  [3:0]  char_bits_i = 4'h8;
   reg         stop_bits_select_i = 1'b0;
   reg         data_read_i = 1'b0;
   reg         status_write_i = 1'b0;
   reg  [2:0]  status_wdata_i = 3'h0;
   reg         hold = 1'b0;
   wire        rxd_i;
   wire [8:0]  rx_data_register_o;
   wire        rx_complete_flag_o, frame_err_flag_o, overrun_flag_o;
   wire        parity_err_flag_o, rx_irq_o, pin_override_o;
   integer     fail_count = 0;
   integer     samples_checked = 0;
   integer     cyc = 0;
   integer     n;
   reg  [11:0] exp_q[$];
   reg  [11:0] e;
   asrx_receiver i_asrx_receiver (.*);
   asrx_line_model i_asrx_line_model (.sys_clk_i(sys_clk_i),
      .os_tick_i(os_tick_i), .rxd_o(rxd_i));
   always #5 sys_clk_i = ~sys_clk_i;
   always @(negedge sys_clk_i) os_tick_i <= ~os_tick_i;
   task test_done;
      if (fail_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task chk(input bit ok);
      samples_checked = samples_checked + 1;
      if (!ok) begin
         fail_count = fail_count + 1;
         $display("CHECK FAILED at %0t: receiver output differs", $time);
      end
   endtask
   task wait_empty;
      integer k;
      for (k = 0; k < 600 && rx_complete_flag_o !== 1'b0; k = k + 1)
         @(negedge sys_clk_i);
      chk(rx_complete_flag_o === 1'b0);
   endtask
   task frame(input [8:0] d, input perr, input stop, input ov, input nt);
      reg [8:0] m;
      m = d & ~(9'h1FF << char_bits_i);
      if (nt)
         exp_q.push_back({~stop, ov, parity_check_enable_i & perr, m});
      i_asrx_line_model.send(m, char_bits_i, parity_check_enable_i,
         ^m ^ parity_odd_select_i ^ perr, stop,
         double_speed_bit_i ? 5'h08 : 5'h10);
   endtask
   // Reader: pops one note per stored frame
   always begin
      @(negedge sys_clk_i);
      if (rx_complete_flag_o === 1'b1 && !hold) begin
         repeat (2) @(negedge sys_clk_i);
         e = exp_q.size() ? exp_q.pop_front() : 12'hFFF;
         chk({frame_err_flag_o, overrun_flag_o, parity_err_flag_o,
            rx_data_register_o} === e);
         data_read_i <= 1'b1;
         @(negedge sys_clk_i);
         data_read_i <= 1'b0;
         repeat (3) @(negedge sys_clk_i);
      end
   end
   always @(posedge sys_clk_i) begin
      cyc = cyc + 1;
      if (cyc == 40000) begin
         fail_count = fail_count + 1;
         test_done;
      end
   end
   initial begin
      void'($urandom(44500));
      repeat (10) @(negedge sys_clk_i);
      reset_i = 1'b0;
      receiver_enable_bit_i = 1'b1;
      rx_done_irq_enable_i = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      i_asrx_line_model.glitch(5'h10);
      frame(9'h0A5, 1'b0, 1'b1, 1'b0, 1'b1);
      for (n = 0; n < 24; n = n + 1) begin
         wait_empty;
         {double_speed_bit_i, parity_check_enable_i, parity_odd_select_i,
            stop_bits_select_i, rx_done_irq_enable_i} = $urandom;
         char_bits_i = 4'h5 + $urandom % 5;
         frame($urandom, $urandom % 4 == 0, $urandom % 5 != 0, 1'b0, 1'b1);
      end
      wait_empty;
      {double_speed_bit_i, parity_check_enable_i, rx_done_irq_enable_i} = 3'h1;
      char_bits_i = 4'h8;
      hold = 1'b1;
      // Last two frames carry equal data: the fourth overwrites the third, which is the one lost
      for (n = 0; n < 4; n = n + 1)
         frame(9'h03C + (n < 3 ? n : 2), 1'b0, 1'b1, n == 2, n < 3);
      status_write_i = 1'b1;
      status_wdata_i = 3'h7;
      @(negedge sys_clk_i);
      status_write_i = 1'b0;
      hold = 1'b0;
      wait_empty;
      frame(9'h0C3, 1'b0, 1'b1, 1'b0, 1'b1);
      wait_empty;
      hold = 1'b1;
      frame(9'h011, 1'b0, 1'b1, 1'b0, 1'b0);
      fork
         frame(9'h022, 1'b0, 1'b1, 1'b0, 1'b0);
         begin
            repeat (150) @(negedge sys_clk_i);
            receiver_enable_bit_i = 1'b0;
            repeat (3) @(negedge sys_clk_i);
            chk(rx_complete_flag_o === 1'b0 && pin_override_o === 1'b0);
         end
      join
      receiver_enable_bit_i = 1'b1;
      hold = 1'b0;
      frame(9'h155, 1'b0, 1'b0, 1'b0, 1'b1);
      wait_empty;
      test_done;
   end
endmodule // testbench
